// ---- lmpks_pkg.sv ----
// constants, field layouts and state types for the led matrix pwm and key scan block
package lmpks_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_MOD_EN = 8'h00;
	localparam logic [7:0] OFF_DUTY_A = 8'h04;
	localparam logic [7:0] OFF_DUTY_B = 8'h08;
	localparam logic [7:0] OFF_DUTY_C = 8'h0C;
	localparam logic [7:0] OFF_CTL0 = 8'h10;
	localparam logic [7:0] OFF_CTL1 = 8'h14;
	localparam logic [7:0] OFF_CTL2 = 8'h18;
	localparam logic [7:0] OFF_CTL3 = 8'h1C;
	localparam logic [7:0] OFF_KEY = 8'h20;
	localparam logic [7:0] OFF_AUTO_A = 8'h40;
	localparam logic [7:0] OFF_AUTO_B = 8'h60;
	localparam logic [7:0] OFF_AUTO_C = 8'h80;
	// ---------------------------------------------------------------
	// field positions and writable masks
	// ---------------------------------------------------------------
	localparam int REP_LSB = 5;
	localparam int CKS_LSB = 2;
	localparam int AUTO_BIT = 0;
	localparam int ROW_LSB = 3;
	localparam int GEN_BIT = 2;
	localparam int SCAN_BIT = 0;
	localparam int DLY_LSB = 4;
	localparam int COMPOL_BIT = 1;
	localparam int SEGPOL_BIT = 0;
	localparam int ACT_LSB = 4;
	localparam logic [7:0] MOD_EN_MASK = 8'h07;
	localparam logic [7:0] CTL0_MASK = 8'hFD;
	localparam logic [7:0] CTL1_MASK = 8'hFD;
	localparam logic [7:0] CTL2_MASK = 8'hF3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] LAST_IDX = 3'h7;
	localparam logic [7:0] CNT_TOP = 8'hFF;
	// ---------------------------------------------------------------
	// pwm clock dividers from the 200 MHz system clock
	// ---------------------------------------------------------------
	localparam logic [7:0] DIV_HOSC = 8'h10;
	localparam logic [7:0] DIV_PLL16 = 8'h0C;
	localparam logic [7:0] DIV_PLL12 = 8'h10;
	localparam logic [7:0] DIV_PLL6 = 8'h20;

	typedef enum logic [1:0] {PH_LOAD, PH_PWM, PH_GAP, PH_DELAY} lmpks_phase_type;

	typedef struct packed {
		logic [2:0] mod_en;
		logic [2:0][7:0] duty;
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [3:0] com_count;
		logic [7:0][7:0] auto_a;
		logic [7:0][7:0] auto_b;
		logic [7:0][7:0] auto_c;
		logic [7:0] key_res;
		logic running;
		lmpks_phase_type phase;
		logic [2:0] slot;
		logic [2:0] rep;
		logic [7:0] cnt;
		logic [7:0] divcnt;
		logic [9:0] dcnt;
		logic [2:0] seg;
		logic [7:0] com;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic frame_req;
		logic scan_req;
	} lmpks_state_type;

	// pwm clock periods in system clocks for each clock select code
	function automatic logic [7:0] lmpks_div(input logic [2:0] sel);
		logic [7:0] d;
		d = DIV_HOSC;
		case (sel[1:0])
			2'h0: d = DIV_HOSC;
			2'h1: d = DIV_PLL16;
			2'h2: d = DIV_PLL12;
			default: d = DIV_PLL6;
		endcase
		if (sel[2]) begin
			d = sel[1] ? {d[5:0], 2'h0} : {d[6:0], 1'h0};
		end
		return d;
	endfunction

	// key scan delay in pwm clock periods
	function automatic logic [9:0] lmpks_delay(input logic [3:0] code);
		return code[3] ? 10'(10'h004 << code[2:0]) : 10'(10'h005 << code[2:0]);
	endfunction

	// highest index enabled by a select field, saturating at seven
	function automatic logic [2:0] lmpks_sat(input logic [4:0] code);
		return (code > 5'(LAST_IDX)) ? LAST_IDX : code[2:0];
	endfunction
endpackage

// ---- lmpks_top.sv ----
// led matrix pwm driver with hardware key scan behind an apb slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - duty registers for a, b and c are writable only in manual mode.
// - repeat code n gives eight minus n waveforms per common.
// - clock select picks the pwm clock source and its divider.
// - configuration writes are ignored in auto mode while globally enabled.
// - manual mode is software driven; auto mode sequences duties and commons.
// - row select n drives key rows zero to n, saturating at seven.
// - with global enable low all outputs are inactive and pwm clock stops.
// - after enable falls in auto mode, operation continues until led and scan frames end; manual mode stops at once.
// - enable falling and rising within a frame causes no interruption.
// - delay code picks 5 to 640 or 4 to 512 pwm periods.
// - common polarity zero means active high, one active low.
// - segment polarity zero means active low, one active high.
// - status field reports the common index being processed.
// - common count n enables commons zero to n, saturating at seven.
// - commons beyond the repeat-derived index still cycle without pwm.
// - key result registers hold the column level in bit zero only.
// - eight sets of auto duty registers for a, b and c reset to zero.
// - three independent eight bit pwm channels each drive a segment.
// - time sharing over up to eight commons gives 24 segment outputs.
// - auto mode loads each common's duties before driving that common.
// - key column is captured when the common output goes inactive.
// - key rows share the common pins; column sampled during their period.
// - in manual mode clearing a channel enable stops it; the shared counter is held at zero only when all three are clear.
// - a frame request pulses after every completed led frame.
// - a scan request pulses after every completed key scan frame.
module lmpks_top
	import lmpks_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic key_column_input,
	output logic [2:0] segment_output,
	output logic [7:0] common_output,
	output logic led_frame_request,
	output logic key_frame_request
);
	lmpks_state_type s_reg;
	lmpks_state_type s_next;

	logic auto_on;
	logic gen_on;
	logic scan_on;
	logic seg_pol;
	logic com_pol;
	logic cfg_open;
	logic tick;
	logic [2:0] rep_last;
	logic [2:0] com_last;
	logic [2:0] row_last;
	logic [2:0] slot_last;
	logic apb_acc;
	logic apb_wr;
	logic gap_done;
	logic delay_done;
	logic advance;
	logic frame_end;
	logic [7:0] div_top;

	assign auto_on = s_reg.ctl0[AUTO_BIT];
	assign gen_on = s_reg.ctl1[GEN_BIT];
	assign scan_on = s_reg.ctl1[SCAN_BIT];
	assign seg_pol = s_reg.ctl2[SEGPOL_BIT];
	assign com_pol = s_reg.ctl2[COMPOL_BIT];
	assign cfg_open = !auto_on || !gen_on;
	assign tick = s_reg.running && (s_reg.divcnt == RESET_BYTE);
	assign rep_last = LAST_IDX - s_reg.ctl0[REP_LSB +: 3];
	assign com_last = lmpks_sat({1'b0, s_reg.com_count});
	assign row_last = scan_on ? lmpks_sat(s_reg.ctl1[ROW_LSB +: 5]) : 3'h0;
	assign slot_last = (row_last > com_last) ? row_last : com_last;
	assign apb_acc = psel && penable && !s_reg.pready;
	assign apb_wr = apb_acc && pwrite;
	assign gap_done = (s_reg.phase == PH_GAP) && !scan_on;
	assign delay_done = (s_reg.phase == PH_DELAY) && tick && (s_reg.dcnt == 10'h000);
	assign advance = s_reg.running && auto_on && (gap_done || delay_done);
	assign frame_end = advance && (s_reg.slot == slot_last);
	assign div_top = 8'(lmpks_div(s_reg.ctl0[CKS_LSB +: 3]) - 8'h01);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [2:0] i;
		logic [2:0] seg_act;
		logic [7:0] com_act;
		logic [7:0] rd;
		logic bad;
		i = paddr[4:2];
		seg_act = 3'h0;
		com_act = 8'h00;
		rd = 8'h00;
		bad = 1'b0;
		s_next = s_reg;
		s_next.frame_req = 1'b0;
		s_next.scan_req = 1'b0;

		// -----------------------------------------------------------
		// apb slave, one wait state
		// -----------------------------------------------------------
		s_next.pready = apb_acc;
		if (apb_acc) begin
			bad = (paddr[1:0] != 2'h0) || (paddr[7:5] > OFF_AUTO_C[7:5]);
			case (paddr[7:5])
				OFF_MOD_EN[7:5]: begin
					case ({i, 2'h0})
						OFF_MOD_EN[4:0]: rd = {5'h00, s_reg.mod_en};
						OFF_DUTY_A[4:0]: rd = s_reg.duty[0];
						OFF_DUTY_B[4:0]: rd = s_reg.duty[1];
						OFF_DUTY_C[4:0]: rd = s_reg.duty[2];
						OFF_CTL0[4:0]: rd = s_reg.ctl0;
						OFF_CTL1[4:0]: rd = s_reg.ctl1;
						OFF_CTL2[4:0]: rd = s_reg.ctl2;
						default: rd = {(s_reg.running ? {1'b0, s_reg.slot} : 4'h0), s_reg.com_count};
					endcase
				end
				OFF_KEY[7:5]: rd = {7'h00, s_reg.key_res[i]};
				OFF_AUTO_A[7:5]: rd = s_reg.auto_a[i];
				OFF_AUTO_B[7:5]: rd = s_reg.auto_b[i];
				OFF_AUTO_C[7:5]: rd = s_reg.auto_c[i];
				default: rd = 8'h00;
			endcase
			s_next.pslverr = bad;
			s_next.prdata = (pwrite || bad) ? 32'h0000_0000 : {24'h00_0000, rd};
		end
		if (apb_wr && !bad) begin
			case (paddr[7:5])
				OFF_MOD_EN[7:5]: begin
					case ({i, 2'h0})
						OFF_MOD_EN[4:0]: s_next.mod_en = pwdata[2:0] & MOD_EN_MASK[2:0];
						OFF_DUTY_A[4:0]: if (!auto_on) s_next.duty[0] = pwdata[7:0];
						OFF_DUTY_B[4:0]: if (!auto_on) s_next.duty[1] = pwdata[7:0];
						OFF_DUTY_C[4:0]: if (!auto_on) s_next.duty[2] = pwdata[7:0];
						OFF_CTL0[4:0]: if (cfg_open) s_next.ctl0 = pwdata[7:0] & CTL0_MASK;
						OFF_CTL1[4:0]: begin
							if (cfg_open) begin
								s_next.ctl1 = pwdata[7:0] & CTL1_MASK;
							end
							s_next.ctl1[GEN_BIT] = pwdata[GEN_BIT];
						end
						OFF_CTL2[4:0]: if (cfg_open) s_next.ctl2 = pwdata[7:0] & CTL2_MASK;
						default: if (cfg_open) s_next.com_count = pwdata[3:0];
					endcase
				end
				OFF_AUTO_A[7:5]: s_next.auto_a[i] = pwdata[7:0];
				OFF_AUTO_B[7:5]: s_next.auto_b[i] = pwdata[7:0];
				OFF_AUTO_C[7:5]: s_next.auto_c[i] = pwdata[7:0];
				default: s_next.mod_en = s_reg.mod_en;
			endcase
		end

		// -----------------------------------------------------------
		// run control and pwm clock
		// -----------------------------------------------------------
		// in auto mode a falling enable is only acted on at a frame boundary, so a quick re-enable is invisible; manual mode stops at once
		if (gen_on && !s_reg.running) begin
			s_next.running = 1'b1;
			s_next.phase = PH_LOAD;
			s_next.slot = 3'h0;
			s_next.cnt = RESET_BYTE;
			s_next.divcnt = RESET_BYTE;
		end else if (!gen_on && s_reg.running && (!auto_on || frame_end)) begin
			s_next.running = 1'b0;
		end
		if (s_reg.running) begin
			s_next.divcnt = tick ? div_top : 8'(s_reg.divcnt - 8'h01);
		end

		// -----------------------------------------------------------
		// manual mode: free-running channels
		// -----------------------------------------------------------
		if (s_reg.running && !auto_on) begin
			if (s_reg.mod_en == 3'h0) begin
				s_next.cnt = RESET_BYTE;
			end else if (tick) begin
				s_next.cnt = 8'(s_reg.cnt + 8'h01);
			end
			for (int c = 0; c < 3; c++) begin
				seg_act[c] = s_reg.mod_en[c] && (s_reg.cnt < s_reg.duty[c]);
			end
		end

		// -----------------------------------------------------------
		// auto mode sequencer
		// -----------------------------------------------------------
		if (s_reg.running && auto_on) begin
			unique case (s_reg.phase)
				PH_LOAD: begin
					s_next.duty[0] = s_reg.auto_a[s_reg.slot];
					s_next.duty[1] = s_reg.auto_b[s_reg.slot];
					s_next.duty[2] = s_reg.auto_c[s_reg.slot];
					s_next.cnt = RESET_BYTE;
					s_next.rep = 3'h0;
					// restart the divider so the first count step is a full pwm period
					s_next.divcnt = div_top;
					s_next.phase = (s_reg.slot > com_last) ? PH_GAP : PH_PWM;
				end
				PH_PWM: begin
					com_act[s_reg.slot] = 1'b1;
					for (int c = 0; c < 3; c++) begin
						seg_act[c] = (s_reg.slot <= rep_last) && (s_reg.cnt < s_reg.duty[c]);
					end
					if (tick) begin
						s_next.cnt = 8'(s_reg.cnt + 8'h01);
						if (s_reg.cnt == CNT_TOP) begin
							if (s_reg.rep == rep_last) begin
								s_next.phase = PH_GAP;
							end else begin
								s_next.rep = 3'(s_reg.rep + 3'h1);
							end
						end
					end
				end
				PH_GAP: begin
					if (scan_on && s_reg.slot <= com_last) begin
						s_next.key_res[s_reg.slot] = key_column_input;
					end
					s_next.dcnt = 10'(lmpks_delay(s_reg.ctl2[DLY_LSB +: 4]) - 10'h001);
					// whole pwm periods in the key delay, not a fraction for the first one
					s_next.divcnt = div_top;
					if (scan_on) begin
						s_next.phase = PH_DELAY;
					end
				end
				PH_DELAY: begin
					com_act[s_reg.slot] = (s_reg.slot > com_last) && (s_reg.slot <= row_last);
					if (tick) begin
						s_next.dcnt = 10'(s_reg.dcnt - 10'h001);
					end
					if (delay_done && com_act[s_reg.slot]) begin
						s_next.key_res[s_reg.slot] = key_column_input;
					end
				end
			endcase
			if (advance) begin
				s_next.phase = PH_LOAD;
				s_next.slot = frame_end ? 3'h0 : 3'(s_reg.slot + 3'h1);
				s_next.frame_req = frame_end;
				s_next.scan_req = frame_end && scan_on;
			end
		end

		// polarity applied here so the pins come straight from flops
		s_next.seg = seg_pol ? seg_act : ~seg_act;
		s_next.com = com_pol ? ~com_act : com_act;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.phase <= PH_LOAD;
			s_reg.seg <= 3'h7;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign prdata = s_reg.prdata;
	assign segment_output = s_reg.seg;
	assign common_output = s_reg.com;
	assign led_frame_request = s_reg.frame_req;
	assign key_frame_request = s_reg.scan_req;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_seg_idle_off: assert property (!s_reg.running ##1 !s_reg.running |-> segment_output == {3{~$past(seg_pol)}})
		else $error("segment active while stopped");
	a_com_idle_off: assert property (!s_reg.running ##1 !s_reg.running |-> common_output == {8{$past(com_pol)}})
		else $error("common active while stopped");
	a_duty_b_lock: assert property (apb_wr && paddr == OFF_DUTY_B && auto_on && s_reg.phase != PH_LOAD
		|=> s_reg.duty[1] == $past(s_reg.duty[1]))
		else $error("duty b written in auto mode");
	a_cfg_lock: assert property (apb_wr && paddr == OFF_CTL2 && !cfg_open |=> $stable(s_reg.ctl2))
		else $error("configuration changed while locked");
	a_stop_frame: assert property (auto_on && $fell(s_reg.running) |-> $past(frame_end) && !$past(gen_on))
		else $error("stopped before frame end");
	a_frame_pulse: assert property (frame_end |=> led_frame_request ##1 !led_frame_request)
		else $error("frame request missing");
	a_scan_pulse: assert property (frame_end && scan_on |=> key_frame_request)
		else $error("scan request missing");
	a_load_duty: assert property (s_reg.running && auto_on && s_reg.phase == PH_LOAD
		|=> s_reg.duty[0] == $past(s_reg.auto_a[s_reg.slot]) && s_reg.phase != PH_LOAD)
		else $error("auto duty not loaded");
	a_key_capture: assert property (s_reg.running && auto_on && s_reg.phase == PH_GAP && scan_on && s_reg.slot <= com_last
		|=> s_reg.key_res[$past(s_reg.slot)] == $past(key_column_input))
		else $error("key column not captured");
endmodule

`default_nettype wire

// ---- lmpks_keys.sv ----
// key matrix model on the shared common and key row pins
`timescale 1ns/1ps
`default_nettype none

module lmpks_keys (
	input wire logic clk,
	input wire logic [7:0] common_output,
	input wire logic [7:0] pressed,
	output logic key_column_input
);
	// column settles one clock after the rows move; pull-up when no pressed key sees an active row
	initial key_column_input = 1'b1;
	always @(posedge clk) begin
		key_column_input <= ~|(common_output & pressed);
	end
endmodule

`default_nettype wire

// ---- lmpks_top_tb.sv ----
// self-checking bench for the led matrix pwm and key scan block
`timescale 1ns/1ps
`default_nettype none

module lmpks_top_tb
	import lmpks_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] pressed = 8'h00;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;
	logic key_column_input;
	logic [2:0] segment_output;
	logic [7:0] common_output;
	logic led_frame_request;
	logic key_frame_request;
	logic [7:0] dut_duty [3][8];
	int acc [3][3] = '{default: 0};
	int snap [3][3] = '{default: 0};
	int kcnt = 0;
	int cycles = 0;
	int fails = 0;
	int cmp_count = 0;

	always #2.5 clk = ~clk;

	lmpks_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.key_column_input(key_column_input), .segment_output(segment_output),
		.common_output(common_output), .led_frame_request(led_frame_request),
		.key_frame_request(key_frame_request));

	lmpks_keys keys (.clk(clk), .common_output(common_output), .pressed(pressed),
		.key_column_input(key_column_input));

	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task automatic final_report();
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// starts on its own edge so a release and the next setup never share a time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'b1) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask

	task automatic wait_frame();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (led_frame_request !== 1'b1 && n < 30000);
		if (led_frame_request !== 1'b1) fails++;
		@(posedge clk);
	endtask

	// clock code 1 gives 12 clocks a tick, repeat code 6 two waveforms, slot 2 is beyond m
	task automatic chk_frame();
		for (int k = 0; k < 3; k++) begin
			for (int c = 0; c < 3; c++) begin
				chk(32'(snap[k][c]), (k < 2) ? 32'(dut_duty[c][k]) * 32'h18 : 32'h0);
			end
		end
	endtask

	function automatic int div_of(input logic [2:0] s);
		return (s == 3'h1) ? 12 : 16;
	endfunction

	// ---------------------------------------------------------------
	// monitors and hang guard
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		for (int k = 0; k < 3; k++) begin
			for (int c = 0; c < 3; c++) begin
				if (led_frame_request === 1'b1) begin
					snap[k][c] <= acc[k][c];
					acc[k][c] <= 0;
				end else if (common_output[k] === 1'b1 && segment_output[c] === 1'b0) begin
					acc[k][c] <= acc[k][c] + 1;
				end
			end
		end
		if (key_frame_request === 1'b1) begin
			kcnt <= kcnt + 1;
		end
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			fails++;
			final_report();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic e;
		int n;
		int nc;
		int bad;
		logic [2:0] sel;
		logic [7:0] d;
		void'($urandom(88));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 32'hA0; a += 4) rdc(8'(a), 32'h0);
		apb(1'b0, 8'hA4, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		d = 8'($urandom);
		sel = 3'($urandom % 3);
		wr(OFF_DUTY_A, d);
		wr(OFF_DUTY_B, 8'hA5);
		wr(OFF_DUTY_C, ~d);
		rdc(OFF_DUTY_B, 32'hA5);
		wr(OFF_MOD_EN, 8'h05);
		wr(OFF_CTL2, 8'h01);
		wr(OFF_CTL0, {3'h0, sel, 2'h0});
		rdc(OFF_CTL0, {27'h0, sel, 2'h0});
		chk({21'h0, segment_output, common_output}, 32'h0);
		wr(OFF_CTL1, 8'h04);
		repeat (8) @(posedge clk);
		n = 0;
		nc = 0;
		bad = 0;
		repeat (256 * div_of(sel)) begin
			@(posedge clk);
			n += (segment_output[0] === 1'b1);
			nc += (segment_output[2] === 1'b1);
			bad += (segment_output[1] !== 1'b0 || common_output !== 8'h00);
		end
		chk(32'(n), 32'(d) * 32'(div_of(sel)));
		chk(32'(nc), 32'(8'(~d)) * 32'(div_of(sel)));
		chk(32'(bad), 32'h0);
		wr(OFF_CTL1, 8'h00);
		wr(OFF_CTL2, 8'h80);
		wr(OFF_CTL3, 8'h02);
		for (int k = 0; k < 8; k++) begin
			for (int c = 0; c < 3; c++) begin
				dut_duty[c][k] = 8'($urandom);
				wr(OFF_AUTO_A + 8'(c * 32 + k * 4), dut_duty[c][k]);
			end
		end
		rdc(OFF_AUTO_C + 8'h1C, {24'h0, dut_duty[2][7]});
		pressed <= 8'($urandom);
		wr(OFF_CTL0, 8'hC5);
		wr(OFF_CTL1, 8'h15);
		wr(OFF_CTL2, 8'h33);
		rdc(OFF_CTL2, 32'h80);
		wr(OFF_DUTY_B, ~dut_duty[1][0]);
		apb(1'b0, OFF_DUTY_B, 32'h0, r, e);
		chk({31'h0, r === {24'h0, dut_duty[1][0]}}, 32'h1);
		rdc(OFF_CTL3, 32'h02);
		wait_frame();
		wait_frame();
		chk_frame();
		for (int k = 0; k < 8; k++) rdc(OFF_KEY + 8'(k * 4), (k < 3) ? {31'h0, ~pressed[k]} : 32'h0);
		chk({31'h0, kcnt > 0}, 32'h1);
		// enable drops and returns within the frame; the next frame must follow at once
		wr(OFF_CTL1, 8'h11);
		wr(OFF_CTL1, 8'h15);
		wait_frame();
		repeat (4) @(posedge clk);
		chk(32'(common_output), 32'h01);
		chk_frame();
		// enable drops early in slot 0; the rest of the frame must still run
		wr(OFF_CTL1, 8'h11);
		wait_frame();
		chk_frame();
		repeat (4) @(posedge clk);
		chk({21'h0, segment_output, common_output}, 32'h700);
		final_report();
	end
endmodule

`default_nettype wire
